/* bench/sbp_ctrl_model.sv */
// sdram controller model driving command, gate and write data
module sbp_ctrl_model (
    input  wire logic        ref_clk_i,
    output logic             cke_o,
    output logic             cs_n_o,
    output logic      [2:0]  cmd_o,
    output logic      [1:0]  bank_o,
    output logic      [12:0] addr_o,
    output logic      [15:0] dq_o,
    output logic             dqm_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // row-to-column and precharge waits in clocks
    localparam int GAP = 2;
    // whole run stays far below the hot refresh_command_interval, so no refresh is owed
    initial {cke_o, cs_n_o, cmd_o, bank_o, addr_o, dq_o, dqm_o} = {2'h3, 3'h7, 32'h0};
    task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a, input logic [15:0] d,
                       input logic m);
        @(posedge ref_clk_i);
        {cs_n_o, cmd_o, bank_o, addr_o, dq_o, dqm_o} <= {c == 3'h7, c, b, a, d, m};
    endtask : cmd
    // idle data line shows the inverse of its last value
    task automatic nop(input logic m);
        cmd(3'h7, 2'h0, 13'h0, ~dq_o, m);
    endtask : nop
    task automatic act(input logic [1:0] b, input logic [12:0] row);
        cmd(sbp_pkg::CMD_ACT, b, row, ~dq_o, 1'b0);
        repeat (GAP) nop(1'b0);
    endtask : act
    task automatic pd_enter();
        cmd(sbp_pkg::CMD_PRE, 2'h0, 13'h0400, ~dq_o, 1'b0);
        repeat (GAP) nop(1'b0);
        gate(1'b0);
    endtask : pd_enter
    task automatic gate(input logic v);
        @(posedge ref_clk_i);
        cke_o <= v;
    endtask : gate
endmodule : sbp_ctrl_model

/* bench/tb_sdram_bank_access_and_power_down.sv */
// sdram core bench
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %0t: %h vs %h", $time, g, e); end end
module tb_sdram_bank_access_and_power_down;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] OK = sbp_pkg::RESP_OKAY;
    logic        ref_clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        cke, cs_n, dqm, oe, awr, wrd, bv, arr, rv;
    logic [2:0]  cmd;
    logic [1:0]  bank, br, rr;
    logic [12:0] addr;
    logic [15:0] dqw, dqr;
    logic [31:0] rd, wd = 32'h0;
    logic [3:0]  awa = 4'h0, ara = 4'h0;
    logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    int          error_cnt = 0;
    int          n_tests = 0;
    always #2.5 ref_clk_i = ~ref_clk_i;
    sbp_ctrl_model ctl (.ref_clk_i(ref_clk_i), .cke_o(cke), .cs_n_o(cs_n), .cmd_o(cmd), .bank_o(bank),
        .addr_o(addr), .dq_o(dqw), .dqm_o(dqm));
    sbp_sdram_core dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(cmd[2]),
        .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .bank_i(bank), .addr_i(addr), .dqm_i(dqm), .dq_i(dqw), .dq_o(dqr),
        .dq_oe_o(oe), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre));
    task automatic conclude();
        $display("compares %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic axi(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, tw, tv;
        logic [33:0] got;
        @(posedge ref_clk_i);
        {awa, ara, wd} <= {a, a, d};
        {awv, wv, bre, arv, rre} <= {w, w, w, !w, !w};
        do begin
            @(negedge ref_clk_i);
            {ta, tw, tv} = w ? {awr, wrd, bv} : {arr, 1'b0, rv};
            got = {w ? br : rr, w ? d : rd};
            @(posedge ref_clk_i);
            if (ta) {awv, arv} <= 2'b00;
            if (tw) wv <= 1'b0;
        end while (tv !== 1'b1);
        {bre, rre} <= 2'b00;
        `CHK(got, {r, d})
    endtask : axi
    task automatic t_regs();
        axi(1'b0, 4'h0, 32'h33, OK);
        axi(1'b1, 4'h0, 32'h22, OK);
        axi(1'b1, 4'h8, 32'h0, sbp_pkg::RESP_SLVERR);
        axi(1'b0, 4'h8, 32'h0, sbp_pkg::RESP_SLVERR);
    endtask : t_regs
    task automatic t_burst();
        logic [15:0] ev [4];
        ev = '{16'hb005, 16'h00a6, 16'hb007, 16'h00a4};
        ctl.act(2'h1, 13'h3);
        for (int k = 0; k < 8; k++)
            ctl.cmd(k % 4 ? 3'h7 : sbp_pkg::CMD_WR, 2'h1, k < 4 ? 13'h4 : 13'h6,
                k < 4 ? 16'(16'ha4 + k) : 16'(16'hb004 + (k + 2) % 4), k > 3 && !k[0]);
        ctl.cmd(sbp_pkg::CMD_RD, 2'h1, 13'h5, ~dqw, 1'b0);
        for (int j = 1; j < 8; j++) begin
            ctl.nop(j == 2);
            @(negedge ref_clk_i);
            if (j > 2) `CHK(oe, j != 5 && j < 7)
            if (j > 2 && j != 5 && j < 7) `CHK(dqr, ev[j - 3])
        end
    endtask : t_burst
    task automatic t_pd();
        ctl.pd_enter();
        axi(1'b0, 4'h4, 32'h10, OK);
        ctl.act(2'h3, 13'h1);
        ctl.gate(1'b1);
        ctl.act(2'h2, 13'h1);
        axi(1'b0, 4'h4, 32'h4, OK);
    endtask : t_pd
    task automatic t_modes();
        logic [15:0] ev [10];
        ev = '{16'hc2, 16'hc3, 16'hc6, 16'hc7, 16'hc4, 16'hc5, 16'hc2, 16'hc3, 16'hc0, 16'hc1};
        axi(1'b1, 4'h0, 32'h2f, OK);
        axi(1'b0, 4'h0, 32'h27, OK);
        ctl.act(2'h0, 13'h2);
        ctl.cmd(sbp_pkg::CMD_WR, 2'h0, 13'h1, 16'h0, 1'b0);
        repeat (9) ctl.nop(1'b0);
        axi(1'b0, 4'h4, 32'h65, OK);
        ctl.cmd(sbp_pkg::CMD_STOP, 2'h0, 13'h0, 16'h0, 1'b0);
        axi(1'b0, 4'h4, 32'h5, OK);
        axi(1'b1, 4'h0, 32'h2b, OK);
        ctl.act(2'h3, 13'h5);
        for (int k = 0; k < 8; k++)
            ctl.cmd(k ? 3'h7 : sbp_pkg::CMD_WR, 2'h3, 13'h412, 16'(16'hc0 + k), 1'b0);
        axi(1'b0, 4'h4, 32'h5, OK);
        ctl.act(2'h3, 13'h5);
        ctl.cmd(sbp_pkg::CMD_RD, 2'h3, 13'h10, 16'h0, 1'b0);
        for (int j = 1; j < 13; j++) begin
            ctl.cmd(j == 2 ? sbp_pkg::CMD_RD : 3'h7, 2'h3, 13'h14, 16'h0, 1'b0);
            @(negedge ref_clk_i);
            if (j > 2) `CHK(dqr, ev[j - 3])
        end
        ctl.cmd(sbp_pkg::CMD_RD, 2'h3, 13'h10, 16'h0, 1'b1);
        ctl.cmd(sbp_pkg::CMD_WR, 2'h3, 13'h10, 16'h0, 1'b1);
        ctl.cmd(sbp_pkg::CMD_STOP, 2'h3, 13'h0, 16'h0, 1'b1);
        repeat (2) begin
            ctl.nop(1'b0);
            @(negedge ref_clk_i);
            `CHK(oe, 1'b0)
        end
    endtask : t_modes
    initial begin
        repeat (6) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        t_regs();
        t_burst();
        t_pd();
        t_modes();
        conclude();
    end
    // the tests need well under 1 us
    initial begin
        #10us;
        error_cnt++;
        conclude();
    end
endmodule : tb_sdram_bank_access_and_power_down

/* src/sbp_mem.sv */
// single-port storage array with registered read data
module sbp_mem (
    input  wire logic                       ref_clk_i,
    input  wire logic                       we_i,
    input  wire logic [sbp_pkg::MEM_AW-1:0] addr_i,
    input  wire logic [sbp_pkg::DQ_W-1:0]   wdata_i,
    output logic      [sbp_pkg::DQ_W-1:0]   rdata_o
);
    logic [sbp_pkg::DQ_W-1:0] mem_q [sbp_pkg::MEM_DEPTH];

    always_ff @(posedge ref_clk_i) begin
        if (we_i) begin
            mem_q[addr_i] <= wdata_i;
        end
        rdata_o <= mem_q[addr_i];
    end
endmodule : sbp_mem

/* src/sbp_pkg.sv */
// constants, encodings and types shared by the sdram bank/burst/power-down core
// Functional notes
// [R01] ras low, cas/we high: activate row
// [R02] controller waits row_to_column_delay before column command
// [R03] column command: we high reads, low writes
// [R04] burst length one, two, four, eight, full page
// [R05] later columns generated, wrap in aligned block
// [R06] full page only with sequential order
// [R07] full-page burst runs until another command
// [R08] controller closes row within row_active_time, refresh
// [R09] column command mid-burst restarts complete new burst
// [R10] controller masks read data before interrupting write
// [R11] bursts may alternate between activated banks
// [R12] read mask: outputs off two clocks later
// [R13] write mask blocks same-edge data word
// [R14] controller precharges all before power-down entry
// [R15] power-down ignores all inputs but clock, gate
// [R16] controller exits power-down before refresh_period ends
// [R17] clock gate entry and exit take one clock
// [R18] hot case_temperature: refresh_command_interval 3.9 us
// [R19] precharge_all_select closes all, else bank chosen
// [R20] auto_precharge_flag closes bank after burst
// [R21] read data after column latency, one word per clock
package sbp_pkg;
    localparam int DQ_W      = 16;
    localparam int BANK_W    = 2;
    localparam int NBANK     = 4;
    localparam int ROW_W     = 4;
    localparam int COL_W     = 8;
    localparam int ADDR_W    = 13;
    localparam int MEM_AW    = BANK_W + ROW_W + COL_W;
    localparam int MEM_DEPTH = 1 << MEM_AW;

    // precharge_all_select on precharge, auto_precharge_flag on column commands
    localparam int PRE_ALL_BIT = 10;

    // command code {ras_n, cas_n, we_n} with cs_n low
    localparam logic [2:0] CMD_ACT  = 3'h3;
    localparam logic [2:0] CMD_RD   = 3'h5;
    localparam logic [2:0] CMD_WR   = 3'h4;
    localparam logic [2:0] CMD_PRE  = 3'h2;
    localparam logic [2:0] CMD_STOP = 3'h6;

    // mode register layout
    localparam int MODE_W  = 7;
    localparam int BL_LSB  = 0;
    localparam int BT_BIT  = 3;
    localparam int CL_LSB  = 4;
    localparam logic [MODE_W-1:0] MODE_RST = 7'h33;
    localparam logic [2:0] BL_1    = 3'h0;
    localparam logic [2:0] BL_2    = 3'h1;
    localparam logic [2:0] BL_4    = 3'h2;
    localparam logic [2:0] BL_8    = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [2:0] CL_1    = 3'h1;
    localparam logic [2:0] CL_2    = 3'h2;
    localparam logic [2:0] CL_3    = 3'h3;

    // axi4-lite register map
    localparam int AXI_AW = 4;
    localparam logic [AXI_AW-1:0] MODE_OFS   = 4'h0;
    localparam logic [AXI_AW-1:0] STATUS_OFS = 4'h4;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        BST_IDLE  = 3'b001,
        BST_READ  = 3'b010,
        BST_WRITE = 3'b100
    } sbp_burst_t;
endpackage : sbp_pkg

/* src/sbp_sdram_core.sv */
// sdram command decode, bank rows, burst engine, data mask, power-down and axi4-lite registers
module sbp_sdram_core (
    input  wire logic                       ref_clk_i,
    input  wire logic                       reset_i,
    input  wire logic                       cke_i,
    input  wire logic                       cs_n_i,
    input  wire logic                       ras_n_i,
    input  wire logic                       cas_n_i,
    input  wire logic                       we_n_i,
    input  wire logic [sbp_pkg::BANK_W-1:0] bank_i,
    input  wire logic [sbp_pkg::ADDR_W-1:0] addr_i,
    input  wire logic                       dqm_i,
    input  wire logic [sbp_pkg::DQ_W-1:0]   dq_i,
    output logic      [sbp_pkg::DQ_W-1:0]   dq_o,
    output logic                            dq_oe_o,
    input  wire logic [sbp_pkg::AXI_AW-1:0] s_axi_awaddr_i,
    input  wire logic                       s_axi_awvalid_i,
    output logic                            s_axi_awready_o,
    input  wire logic [31:0]                s_axi_wdata_i,
    input  wire logic [3:0]                 s_axi_wstrb_i,
    input  wire logic                       s_axi_wvalid_i,
    output logic                            s_axi_wready_o,
    output logic      [1:0]                 s_axi_bresp_o,
    output logic                            s_axi_bvalid_o,
    input  wire logic                       s_axi_bready_i,
    input  wire logic [sbp_pkg::AXI_AW-1:0] s_axi_araddr_i,
    input  wire logic                       s_axi_arvalid_i,
    output logic                            s_axi_arready_o,
    output logic      [31:0]                s_axi_rdata_o,
    output logic      [1:0]                 s_axi_rresp_o,
    output logic                            s_axi_rvalid_o,
    input  wire logic                       s_axi_rready_i
);
    localparam int CW = sbp_pkg::COL_W;

    // aligned-block mask for a burst length code; full page spans the whole row
    function automatic logic [CW-1:0] sbp_blk_mask(input logic [2:0] bl);
        logic [CW-1:0] m;
        m = '1;
        case (bl)
            sbp_pkg::BL_1: m = CW'(0);
            sbp_pkg::BL_2: m = CW'(1);
            sbp_pkg::BL_4: m = CW'(3);
            sbp_pkg::BL_8: m = CW'(7);
            default:       m = '1;
        endcase
        return m;
    endfunction : sbp_blk_mask

    // column of burst step idx: sequential adds, interleaved xors, both wrap in the block
    function automatic logic [CW-1:0] sbp_burst_col(input logic [CW-1:0] start, input logic [CW-1:0] idx,
                                                    input logic [2:0] bl, input logic bt);
        logic [CW-1:0] m;
        logic [CW-1:0] off;
        m   = sbp_blk_mask(bl);
        off = bt ? (start ^ idx) : CW'(start + idx);
        return (start & ~m) | (off & m);
    endfunction : sbp_burst_col

    logic                                cke_q;
    logic [sbp_pkg::MODE_W-1:0]          mode_q,  mode_d;
    logic [sbp_pkg::NBANK-1:0]           open_q,  open_d;
    logic [sbp_pkg::ROW_W-1:0]           row_q [sbp_pkg::NBANK];
    logic [sbp_pkg::ROW_W-1:0]           row_d [sbp_pkg::NBANK];
    sbp_pkg::sbp_burst_t                 state_q, state_d;
    logic [CW-1:0]                       idx_q,   idx_d;
    logic [CW-1:0]                       start_q, start_d;
    logic [sbp_pkg::BANK_W-1:0]          bbank_q, bbank_d;
    logic                                ap_q,    ap_d;
    logic                                v0_q, p1_v_q, p2_v_q, rdv_q, m1_q, m2_q, oe_q;
    logic                                v0_d, p1_v_d, p2_v_d, rdv_d, m1_d, m2_d, oe_d;
    logic [sbp_pkg::DQ_W-1:0]            p1_q, p2_q, dq_q, p1_d, p2_d, dq_d;

    // command decode; inputs count only when the gate was high one edge earlier
    logic [2:0] cmd;
    logic       cmd_ok, act_go, rd_go, wr_go, pre_go, stop_go, col_go;
    assign cmd     = {ras_n_i, cas_n_i, we_n_i};
    assign cmd_ok  = cke_q && !cs_n_i;                                   // [R15] [R17]
    assign act_go  = cmd_ok && (cmd == sbp_pkg::CMD_ACT);                // [R01]
    assign rd_go   = cmd_ok && (cmd == sbp_pkg::CMD_RD);                 // [R03]
    assign wr_go   = cmd_ok && (cmd == sbp_pkg::CMD_WR);                 // [R03]
    assign pre_go  = cmd_ok && (cmd == sbp_pkg::CMD_PRE);
    assign stop_go = cmd_ok && (cmd == sbp_pkg::CMD_STOP);
    assign col_go  = rd_go || wr_go;

    logic [2:0]    bl, cl;
    logic          bt, full_page, busy, pre_hits, xfer, last_xfer, single, close_old, close_new;
    logic [CW-1:0] blk_mask, cur_col;
    assign bl        = mode_q[sbp_pkg::BL_LSB +: 3];
    assign bt        = mode_q[sbp_pkg::BT_BIT];
    assign cl        = mode_q[sbp_pkg::CL_LSB +: 3];
    assign full_page = (bl == sbp_pkg::BL_FULL);
    assign blk_mask  = sbp_blk_mask(bl);
    assign single    = (bl == sbp_pkg::BL_1);
    assign busy      = (state_q != sbp_pkg::BST_IDLE);
    assign pre_hits  = pre_go && (addr_i[sbp_pkg::PRE_ALL_BIT] || bank_i == bbank_q);
    assign xfer      = busy && cke_q && !col_go && !stop_go && !pre_hits;
    assign last_xfer = xfer && !full_page && (idx_q == blk_mask);       // [R04] [R07]
    assign cur_col   = sbp_burst_col(start_q, idx_q, bl, bt);           // [R05]
    assign close_old = ap_q && busy && (last_xfer || (col_go && bank_i != bbank_q));   // [R20]
    assign close_new = col_go && single && addr_i[sbp_pkg::PRE_ALL_BIT];               // [R20]

    // burst engine
    always_comb begin
        state_d = state_q;
        idx_d   = idx_q;
        start_d = start_q;
        bbank_d = bbank_q;
        ap_d    = ap_q;
        if (col_go) begin                                                // [R09]
            start_d = addr_i[CW-1:0];
            bbank_d = bank_i;
            ap_d    = addr_i[sbp_pkg::PRE_ALL_BIT];
            idx_d   = CW'(1);
            if (single) begin
                state_d = sbp_pkg::BST_IDLE;
            end else if (rd_go) begin
                state_d = sbp_pkg::BST_READ;                             // [R03]
            end else begin
                state_d = sbp_pkg::BST_WRITE;
            end
        end else if (busy && cke_q && (stop_go || pre_hits)) begin
            state_d = sbp_pkg::BST_IDLE;
        end else if (last_xfer) begin                                    // [R04]
            state_d = sbp_pkg::BST_IDLE;
        end else if (xfer) begin                                         // [R07]
            idx_d = CW'(idx_q + CW'(1));
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= sbp_pkg::BST_IDLE;
            idx_q   <= '0;
            start_q <= '0;
            bbank_q <= '0;
            ap_q    <= 1'b0;
            cke_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            idx_q   <= idx_d;
            start_q <= start_d;
            bbank_q <= bbank_d;
            ap_q    <= ap_d;
            cke_q   <= cke_i;                                            // [R17]
        end
    end

    // per-bank open flag and open row
    always_comb begin
        for (int b = 0; b < sbp_pkg::NBANK; b++) begin
            open_d[b] = open_q[b];
            row_d[b]  = row_q[b];
            if (act_go && bank_i == sbp_pkg::BANK_W'(b)) begin           // [R01] [R11]
                open_d[b] = 1'b1;
                row_d[b]  = addr_i[sbp_pkg::ROW_W-1:0];
            end
            if (pre_go && (addr_i[sbp_pkg::PRE_ALL_BIT] || bank_i == sbp_pkg::BANK_W'(b))) begin
                open_d[b] = 1'b0;                                        // [R19]
            end
            if ((close_old && bbank_q == sbp_pkg::BANK_W'(b)) || (close_new && bank_i == sbp_pkg::BANK_W'(b))) begin
                open_d[b] = 1'b0;                                        // [R20]
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            open_q <= '0;
            for (int b = 0; b < sbp_pkg::NBANK; b++) begin
                row_q[b] <= '0;
            end
        end else begin
            open_q <= open_d;
            row_q  <= row_d;
        end
    end

    // storage access: new column command wins over the running burst
    logic                          rd_issue, wr_issue, mem_we;
    logic [sbp_pkg::MEM_AW-1:0]    mem_addr;
    logic [sbp_pkg::DQ_W-1:0]      mem_rdata;
    assign rd_issue = rd_go || (xfer && state_q == sbp_pkg::BST_READ);
    assign wr_issue = wr_go || (xfer && state_q == sbp_pkg::BST_WRITE);
    assign mem_we   = wr_issue && !dqm_i;                                // [R13]
    assign mem_addr = col_go ? {bank_i, row_q[bank_i], addr_i[CW-1:0]}
                             : {bbank_q, row_q[bbank_q], cur_col};       // [R11]

    sbp_mem u_mem (
        .ref_clk_i (ref_clk_i),
        .we_i      (mem_we),
        .addr_i    (mem_addr),
        .wdata_i   (dq_i),
        .rdata_o   (mem_rdata)
    );

    // read latency pipeline and read mask; a read cut by a write relies on the controller's mask [R10]
    always_comb begin
        v0_d   = rd_issue;
        p1_v_d = v0_q;
        p1_d   = mem_rdata;
        p2_v_d = p1_v_q;
        p2_d   = p1_q;
        m1_d   = cke_q ? dqm_i : m1_q;
        m2_d   = m1_q;
        case (cl)                                                        // [R21]
            sbp_pkg::CL_1: begin
                rdv_d = v0_q;
                dq_d  = mem_rdata;
            end
            sbp_pkg::CL_2: begin
                rdv_d = p1_v_q;
                dq_d  = p1_q;
            end
            default: begin
                rdv_d = p2_v_q;
                dq_d  = p2_q;
            end
        endcase
        oe_d = rdv_d && !m2_q;                                           // [R12]
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            v0_q   <= 1'b0;
            p1_v_q <= 1'b0;
            p2_v_q <= 1'b0;
            rdv_q  <= 1'b0;
            m1_q   <= 1'b0;
            m2_q   <= 1'b0;
            oe_q   <= 1'b0;
            p1_q   <= '0;
            p2_q   <= '0;
            dq_q   <= '0;
        end else begin
            v0_q   <= v0_d;
            p1_v_q <= p1_v_d;
            p2_v_q <= p2_v_d;
            rdv_q  <= rdv_d;
            m1_q   <= m1_d;
            m2_q   <= m2_d;
            oe_q   <= oe_d;
            p1_q   <= p1_d;
            p2_q   <= p2_d;
            dq_q   <= dq_d;
        end
    end

    assign dq_o    = dq_q;
    assign dq_oe_o = oe_q;

    // axi4-lite slave: mode register and status
    logic                        aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic                        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [sbp_pkg::AXI_AW-1:0]  aw_addr_q, aw_addr_d;
    logic [31:0]                 w_data_q, w_data_d, rdata_q, rdata_d;
    logic [3:0]                  w_strb_q, w_strb_d;
    logic [1:0]                  bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0]                 status;
    logic [2:0]                  wr_bl, wr_cl;
    logic                        wr_mode_ok;

    assign s_axi_awready_o = !aw_have_q && !bvalid_q;
    assign s_axi_wready_o  = !w_have_q && !bvalid_q;
    assign s_axi_arready_o = !rvalid_q;
    assign status     = {25'h0, state_q == sbp_pkg::BST_WRITE, busy, !cke_q, open_q};
    assign wr_bl      = w_data_q[sbp_pkg::BL_LSB +: 3];
    assign wr_cl      = w_data_q[sbp_pkg::CL_LSB +: 3];
    assign wr_mode_ok = (wr_bl <= sbp_pkg::BL_8 || wr_bl == sbp_pkg::BL_FULL) &&
                        (wr_cl >= sbp_pkg::CL_1 && wr_cl <= sbp_pkg::CL_3);

    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d  = w_have_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        mode_d    = mode_q;
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_have_d = 1'b1;
            aw_addr_d = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_have_d = 1'b1;
            w_data_d = s_axi_wdata_i;
            w_strb_d = s_axi_wstrb_i;
        end
        if (aw_have_q && w_have_q) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = sbp_pkg::RESP_SLVERR;
            if (aw_addr_q == sbp_pkg::MODE_OFS && wr_mode_ok) begin
                bresp_d = sbp_pkg::RESP_OKAY;
                if (w_strb_q[0]) begin
                    mode_d = w_data_q[sbp_pkg::MODE_W-1:0];
                    if (wr_bl == sbp_pkg::BL_FULL) begin
                        mode_d[sbp_pkg::BT_BIT] = 1'b0;                 // [R06]
                    end
                end
            end
        end else if (bvalid_q && s_axi_bready_i) begin
            bvalid_d = 1'b0;
        end
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            rvalid_d = 1'b1;
            rresp_d  = sbp_pkg::RESP_OKAY;
            if (s_axi_araddr_i == sbp_pkg::MODE_OFS) begin
                rdata_d = {25'h0, mode_q};
            end else if (s_axi_araddr_i == sbp_pkg::STATUS_OFS) begin
                rdata_d = status;
            end else begin
                rdata_d = 32'h0;
                rresp_d = sbp_pkg::RESP_SLVERR;
            end
        end else if (rvalid_q && s_axi_rready_i) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_have_q  <= 1'b0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= sbp_pkg::RESP_OKAY;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= sbp_pkg::RESP_OKAY;
            mode_q    <= sbp_pkg::MODE_RST;
        end else begin
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q  <= w_have_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
            mode_q    <= mode_d;
        end
    end

    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o  = bresp_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o  = rdata_q;
    assign s_axi_rresp_o  = rresp_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_bl4_start;
        col_go && bl == sbp_pkg::BL_4;
    endsequence
    sequence s_run3;
        (cke_q && !col_go && !stop_go && !pre_go)[*3];
    endsequence

    act_opens_row_a: assert property (act_go |=> open_q[$past(bank_i)] &&    // [R01]
                                      row_q[$past(bank_i)] == $past(addr_i[sbp_pkg::ROW_W-1:0]))
        else $error("activation did not open the row");
    col_kind_a: assert property ((col_go && !single) |=>                         // [R03]
                                 state_q == ($past(we_n_i) ? sbp_pkg::BST_READ : sbp_pkg::BST_WRITE))
        else $error("column command took the wrong direction");
    burst_len_four_a: assert property (s_bl4_start ##1 s_run3 |=> !busy)        // [R04]
        else $error("four-word burst did not end after four words");
    interleave_order_a: assert property ((col_go && bl == sbp_pkg::BL_8 && bt) ##1 (cke_q && !col_go) |-> // [R05]
                                         mem_addr[2:0] == ($past(addr_i[2:0]) ^ 3'h1) &&
                                         mem_addr[CW-1:3] == $past(addr_i[CW-1:3]))
        else $error("interleaved second column wrong");
    full_page_runs_a: assert property ((busy && full_page && xfer) |=> busy)     // [R07]
        else $error("full-page burst stopped by itself");
    interrupt_restart_a: assert property ((busy && col_go && !single) |=>        // [R09]
                                          idx_q == CW'(1) && start_q == $past(addr_i[CW-1:0]))
        else $error("interrupting column command did not restart the burst");
    read_latency_a: assert property ((rd_go && cl == sbp_pkg::CL_2) |-> ##3 rdv_q) // [R21]
        else $error("read word not driven at column latency");
    read_mask_off_a: assert property ((cke_q && dqm_i) |-> ##3 !dq_oe_o)        // [R12]
        else $error("read mask did not float outputs two clocks later");
    write_mask_a: assert property (wr_issue |-> (mem_we == !dqm_i))             // [R13]
        else $error("write mask not applied on the same edge");
    pd_freeze_a: assert property (!cke_q |=> $stable(open_q) && $stable(state_q) && $stable(idx_q)) // [R15]
        else $error("state changed while the clock gate was low");
    pre_all_a: assert property ((pre_go && addr_i[sbp_pkg::PRE_ALL_BIT]) |=> open_q == '0) // [R19]
        else $error("precharge all left a bank open");
    auto_pre_a: assert property ((last_xfer && ap_q) |=> !open_q[$past(bbank_q)]) // [R20]
        else $error("auto precharge did not close the bank");
endmodule : sbp_sdram_core
